// ==== rtl/cdkd_pkg.sv ====
/*
 * Constants, register map and state encoding for the carrier detect and
 * key-up delay block.
 * Assumes a single 20 MHz clock and a plain strobe register port.
 */
`default_nettype none

package cdkd_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CDKD_CLK_HZ = 20_000_000;
   localparam int CDKD_KEYUP_UNIT_MS = 10;
   localparam int CDKD_TICK_CYCLES = CDKD_CLK_HZ / 1000 * CDKD_KEYUP_UNIT_MS;
   localparam int CDKD_TICK_W = 18;

   // ****************************************************************
   // Register port
   // ****************************************************************
   localparam int CDKD_ADDR_W = 8;
   localparam int CDKD_DATA_W = 32;
   localparam logic [7:0] CDKD_ADDR_RISE = 8'h00;
   localparam logic [7:0] CDKD_ADDR_FALL = 8'h04;
   localparam logic [7:0] CDKD_ADDR_THRESH = 8'h08;
   localparam logic [7:0] CDKD_ADDR_KEYUP = 8'h0C;
   localparam logic [7:0] CDKD_ADDR_STATUS = 8'h10;

   // Reset values of the settings
   localparam logic [7:0] CDKD_RISE_RST = 8'h11;
   localparam logic [7:0] CDKD_FALL_RST = 8'h11;
   localparam logic [7:0] CDKD_THRESH_RST = 8'h6C;
   localparam logic [7:0] CDKD_KEYUP_RST = 8'h1E;

   // Status word fields
   localparam int CDKD_ST_SENSE = 0;
   localparam int CDKD_ST_PTT = 1;
   localparam int CDKD_ST_KEYUP = 2;
   localparam int CDKD_ST_CNT_LSB = 8;

   // ****************************************************************
   // Counter and framing
   // ****************************************************************
   localparam logic [7:0] CDKD_CNT_MAX = 8'hFF;
   localparam logic [7:0] CDKD_CNT_ZERO = 8'h00;
   localparam logic [7:0] CDKD_FLAG = 8'h7E;

   typedef enum logic [2:0] {
      CDKD_IDLE = 3'b001,
      CDKD_KEYUP = 3'b010,
      CDKD_DATA = 3'b100
   } cdkd_state_t;

endpackage : cdkd_pkg

`default_nettype wire

// ==== rtl/cdkd_top.sv ====
/*
 * Carrier detect by transition timing, and transmitter key-up delay
 * that sends flags between push-to-talk and the first data byte.
 * Assumes the receiver supplies the demodulated level with bit-start and
 * mid-bit pulses, and the radio serializer pulses byte_slot_in whenever
 * it wants the next byte. All inputs are synchronous to ref_clk_in.
 */
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Transition at bit start adds the rise setting to the detect counter.
// - Transition at mid bit subtracts the fall penalty from the counter.
// - Carrier sense asserts once the counter reaches the threshold.
// - Carrier sense stays asserted until the counter falls to zero.
// - Request keys push-to-talk, then waits setting times 10 ms before data.
// - Flags are sent throughout the key-up interval.
module cdkd_top
   import cdkd_pkg::*;
#(
   parameter int KEYUP_TICK_CYCLES = CDKD_TICK_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [CDKD_ADDR_W-1:0] reg_addr_in,
   input wire logic [CDKD_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [CDKD_DATA_W-1:0] reg_rdata_out,
   input wire logic rx_level_in,
   input wire logic bit_start_in,
   input wire logic bit_mid_in,
   output logic carrier_sense_out,
   input wire logic tx_req_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_take_out,
   input wire logic byte_slot_in,
   output logic ptt_out,
   output logic [7:0] tx_byte_out,
   output logic tx_load_out
);

   localparam logic [CDKD_TICK_W-1:0] TICK_LAST = CDKD_TICK_W'(KEYUP_TICK_CYCLES - 1);

   // ****************************************************************
   // Settings registers
   // ****************************************************************
   logic [7:0] rise_step;
   logic [7:0] fall_step;
   logic [7:0] sense_thresh;
   logic [7:0] keyup_delay_setting;
   logic [7:0] detect_count;
   logic [7:0] next_count;
   logic rx_prev;
   logic edge_start;
   logic edge_mid;
   logic next_sense;
   cdkd_state_t state;
   logic [CDKD_TICK_W-1:0] tick_cnt;
   logic [7:0] unit_cnt;
   logic [7:0] keyup_units;
   logic tick_wrap;

   // Writes to the four settings; other addresses are ignored
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rise_step <= CDKD_RISE_RST;
         fall_step <= CDKD_FALL_RST;
         sense_thresh <= CDKD_THRESH_RST;
         keyup_delay_setting <= CDKD_KEYUP_RST;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            CDKD_ADDR_RISE: rise_step <= reg_wdata_in[7:0];
            CDKD_ADDR_FALL: fall_step <= reg_wdata_in[7:0];
            CDKD_ADDR_THRESH: sense_thresh <= reg_wdata_in[7:0];
            CDKD_ADDR_KEYUP: keyup_delay_setting <= reg_wdata_in[7:0];
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise and when unmapped
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            CDKD_ADDR_RISE: reg_rdata_out <= {24'h000000, rise_step};
            CDKD_ADDR_FALL: reg_rdata_out <= {24'h000000, fall_step};
            CDKD_ADDR_THRESH: reg_rdata_out <= {24'h000000, sense_thresh};
            CDKD_ADDR_KEYUP: reg_rdata_out <= {24'h000000, keyup_delay_setting};
            CDKD_ADDR_STATUS: begin
               reg_rdata_out <= '0;
               reg_rdata_out[CDKD_ST_SENSE] <= carrier_sense_out;
               reg_rdata_out[CDKD_ST_PTT] <= ptt_out;
               reg_rdata_out[CDKD_ST_KEYUP] <= (state == CDKD_KEYUP);
               reg_rdata_out[CDKD_ST_CNT_LSB +: 8] <= detect_count;
            end
            default: reg_rdata_out <= '0;
         endcase
      end else begin
         reg_rdata_out <= '0;
      end
   end

   // ****************************************************************
   // Carrier detect
   // ****************************************************************

   // Saturating step; a 9-bit sum keeps the overflow visible
   function automatic logic [7:0] cdkd_step(input logic [7:0] cnt, input logic [7:0] up,
                                            input logic [7:0] dn, input logic add, input logic sub);
      logic [8:0] sum;
      sum = {1'b0, cnt} + {1'b0, up};
      if (add) begin
         cdkd_step = sum[8] ? CDKD_CNT_MAX : sum[7:0];
      end else if (sub) begin
         cdkd_step = (cnt < dn) ? CDKD_CNT_ZERO : 8'(cnt - dn);
      end else begin
         cdkd_step = cnt;
      end
   endfunction : cdkd_step

   // Both timing pulses at once is ambiguous, so that edge counts as neither
   assign edge_start = (rx_level_in != rx_prev) && bit_start_in && !bit_mid_in;
   assign edge_mid = (rx_level_in != rx_prev) && bit_mid_in && !bit_start_in;
   assign next_count = cdkd_step(detect_count, rise_step, fall_step, edge_start, edge_mid);
   // Set has priority, so a zero threshold holds sense on
   assign next_sense = (next_count >= sense_thresh) ? 1'b1 :
                       (next_count == CDKD_CNT_ZERO) ? 1'b0 : carrier_sense_out;

   // Counter and sense flip-flops move together
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rx_prev <= 1'b0;
         detect_count <= CDKD_CNT_ZERO;
         carrier_sense_out <= 1'b0;
      end else begin
         rx_prev <= rx_level_in;
         detect_count <= next_count;
         carrier_sense_out <= next_sense;
      end
   end

   // ****************************************************************
   // Key-up delay and framing
   // ****************************************************************
   assign tick_wrap = (tick_cnt == TICK_LAST);

   // Sequencer: the delay is latched at the request so a write mid-interval is harmless
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= CDKD_IDLE;
         ptt_out <= 1'b0;
         tick_cnt <= '0;
         unit_cnt <= '0;
         keyup_units <= '0;
      end else begin
         case (state)
            CDKD_IDLE: begin
               tick_cnt <= '0;
               unit_cnt <= '0;
               if (tx_req_in) begin
                  ptt_out <= 1'b1;
                  keyup_units <= keyup_delay_setting;
                  state <= (keyup_delay_setting == 8'h00) ? CDKD_DATA : CDKD_KEYUP;
               end
            end
            CDKD_KEYUP: begin
               tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
               if (tick_wrap) begin
                  unit_cnt <= unit_cnt + 8'h01;
                  if (unit_cnt + 8'h01 == keyup_units) begin
                     state <= CDKD_DATA;
                  end
               end
            end
            CDKD_DATA: begin
               // No byte ready at a slot ends the frame and unkeys
               if (byte_slot_in && !tx_valid_in) begin
                  ptt_out <= 1'b0;
                  state <= CDKD_IDLE;
               end
            end
            default: begin
               ptt_out <= 1'b0;
               state <= CDKD_IDLE;
            end
         endcase
      end
   end

   // Byte feed to the radio serializer
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tx_byte_out <= CDKD_FLAG;
         tx_load_out <= 1'b0;
         tx_take_out <= 1'b0;
      end else begin
         tx_load_out <= 1'b0;
         tx_take_out <= 1'b0;
         if (byte_slot_in && state == CDKD_KEYUP) begin
            tx_byte_out <= CDKD_FLAG;
            tx_load_out <= 1'b1;
         end else if (byte_slot_in && state == CDKD_DATA && tx_valid_in) begin
            tx_byte_out <= tx_data_in;
            tx_load_out <= 1'b1;
            tx_take_out <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_rise_add;
      @(posedge ref_clk_in) disable iff (rst_in)
      (edge_start && ({1'b0, detect_count} + {1'b0, rise_step} <= 9'h0FF))
         |=> detect_count == 8'($past(detect_count) + $past(rise_step));
   endproperty
   a_rise_add: assert property (p_rise_add) else $error("rise step not added");

   property p_fall_sub;
      @(posedge ref_clk_in) disable iff (rst_in)
      (edge_mid && detect_count >= fall_step) |=> detect_count == 8'($past(detect_count) - $past(fall_step));
   endproperty
   a_fall_sub: assert property (p_fall_sub) else $error("fall penalty not subtracted");

   property p_sense_set;
      @(posedge ref_clk_in) disable iff (rst_in)
      (detect_count >= $past(sense_thresh)) |-> carrier_sense_out;
   endproperty
   a_sense_set: assert property (p_sense_set) else $error("sense missing at threshold");

   property p_sense_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      ($past(carrier_sense_out) && detect_count != CDKD_CNT_ZERO) |-> carrier_sense_out;
   endproperty
   a_sense_hold: assert property (p_sense_hold) else $error("sense dropped above zero");

   property p_sense_clear;
      @(posedge ref_clk_in) disable iff (rst_in)
      (detect_count == CDKD_CNT_ZERO && $past(sense_thresh) != 8'h00) |-> !carrier_sense_out;
   endproperty
   a_sense_clear: assert property (p_sense_clear) else $error("sense stuck at zero count");

   property p_keyup_start;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state == CDKD_IDLE && tx_req_in) |=> ptt_out && state != CDKD_IDLE;
   endproperty
   a_keyup_start: assert property (p_keyup_start) else $error("request did not key");

   property p_keyup_end;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state == CDKD_KEYUP) ##1 (state == CDKD_DATA)
         |-> $past(tick_wrap) && $past(unit_cnt) + 8'h01 == keyup_units;
   endproperty
   a_keyup_end: assert property (p_keyup_end) else $error("key-up interval wrong length");

   property p_flag_fill;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state == CDKD_KEYUP && byte_slot_in) |=> tx_load_out && tx_byte_out == CDKD_FLAG && !tx_take_out;
   endproperty
   a_flag_fill: assert property (p_flag_fill) else $error("no flag during key-up");

   property p_sat;
      @(posedge ref_clk_in) disable iff (rst_in)
      (edge_mid && detect_count < fall_step) ##1 1'b1 |-> detect_count == CDKD_CNT_ZERO;
   endproperty
   a_sat: assert property (p_sat) else $error("counter wrapped below zero");

   property p_sat_top;
      @(posedge ref_clk_in) disable iff (rst_in)
      (edge_start && ({1'b0, detect_count} + {1'b0, rise_step} > 9'h0FF)) |=> detect_count == CDKD_CNT_MAX;
   endproperty
   a_sat_top: assert property (p_sat_top) else $error("counter wrapped above max");

endmodule : cdkd_top

`default_nettype wire

// ==== tb/cdkd_radio.sv ====
/* Radio serializer model for the far side of the transmit port.
   Assumes push-to-talk keys it; asks for one byte every gap+1 cycles. */
`timescale 1ns/1ps
`default_nettype none
module cdkd_radio (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ptt_in,
   input wire logic [3:0] gap_in,
   output logic slot_out
);
   logic [3:0] cnt;
   // Unkeyed radio never asks, so no slot outside a frame
   always_ff @(posedge clk_in) begin
      if (rst_in || !ptt_in) begin
         cnt <= 4'h0;
         slot_out <= 1'b0;
      end else begin
         cnt <= (cnt >= gap_in) ? 4'h0 : cnt + 4'h1;
         slot_out <= cnt >= gap_in;
      end
   end
endmodule : cdkd_radio
`default_nettype wire

// ==== tb/tb.sv ====
/* Self-checking bench: reference model of detect counter and key-up framing.
   Assumes cdkd_radio on the far side and a short tick parameter. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cdkd_pkg::*;
   localparam int TK = 4;
   logic ref_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic rx_level_in = 0, bit_start_in = 0, bit_mid_in = 0;
   logic tx_req_in = 0, tx_valid_in = 0, byte_slot_in;
   logic [7:0] reg_addr_in = 8'h00, tx_data_in = 8'h00, tx_byte_out, b_m;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rnd = 32'h6EE5037F;
   logic carrier_sense_out, tx_take_out, ptt_out, tx_load_out;
   logic [3:0] gap = 4'h3;
   int n_errors = 0, check_count = 0, cyc = 0, t = 0, kset = 0;
   int ks[3] = '{0, 1, 3};
   bit go = 0, busy = 0, tx_on = 0, ptt_m = 0, ld_m = 0, tk_m = 0;
   logic [7:0] q[$];

   always #25 ref_clk_in = ~ref_clk_in;

   cdkd_top #(.KEYUP_TICK_CYCLES(TK)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_level_in(rx_level_in),
      .bit_start_in(bit_start_in), .bit_mid_in(bit_mid_in), .carrier_sense_out(carrier_sense_out),
      .tx_req_in(tx_req_in), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
      .tx_take_out(tx_take_out), .byte_slot_in(byte_slot_in), .ptt_out(ptt_out),
      .tx_byte_out(tx_byte_out), .tx_load_out(tx_load_out));
   cdkd_radio u_radio (.clk_in(ref_clk_in), .rst_in(rst_in), .ptt_in(ptt_out), .gap_in(gap),
      .slot_out(byte_slot_in));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   function automatic logic [31:0] nxt(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction : nxt
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One strobe cycle; for a read d is the expected data
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      reg_wr_in <= w;
      reg_rd_in <= !w;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      @(negedge ref_clk_in);
      if (!w) chk("rdata", reg_rdata_out, d);
   endtask : bus
   task automatic rst;
      @(posedge ref_clk_in);
      rst_in <= 1'b1;
      rx_level_in <= 1'b0;
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
   endtask : rst
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // Random transitions; model evaluated one edge behind the drive
   task automatic cdp(input int u, input int d, input int th);
      int c;
      bit s;
      bit m;
      logic [31:0] x;
      rst();
      bus(1, CDKD_ADDR_RISE, u);
      bus(1, CDKD_ADDR_FALL, d);
      bus(1, CDKD_ADDR_THRESH, th);
      c = 0;
      s = 0;
      repeat (300) begin
         @(posedge ref_clk_in);
         rnd = nxt(rnd);
         x = rnd;
         m = x[2] & x[3] | x[1] & x[4] & x[5];
         rx_level_in <= rx_level_in ^ x[0];
         bit_start_in <= x[1];
         bit_mid_in <= m;
         @(negedge ref_clk_in);
         chk("sense", carrier_sense_out, s);
         if (x[0] && x[1] && !m) c = (c + u > 255) ? 255 : c + u;
         if (x[0] && m && !x[1]) c = (c < d) ? 0 : c - d;
         if (c >= th) s = 1;
         else if (c == 0) s = 0;
      end
      bus(0, CDKD_ADDR_STATUS, {16'h0, c[7:0], 7'h0, s});
      $display("detect test %0d/%0d/%0d done", u, d, th);
   endtask : cdp

   // Timeout, well above the expected run length
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   // Transmit model: slot at edge t in 1..setting*TK gets a flag
   always @(posedge ref_clk_in) begin
      if (tx_on) begin
         chk("ptt", ptt_out, ptt_m);
         chk("load", tx_load_out, ld_m);
         chk("take", tx_take_out, tk_m);
         if (ld_m) chk("byte", tx_byte_out, b_m);
         if (tk_m) void'(q.pop_front());
         ld_m = 0;
         tk_m = 0;
         t++;
         if (go) begin
            tx_req_in <= 1'b1;
            go = 0;
            t = -1;
         end
         // Request held one extra edge: must be ignored once keyed
         if (t == 1) tx_req_in <= 1'b0;
         if (t == 0) ptt_m = 1;
         else if (byte_slot_in && ptt_m) begin
            ld_m = t <= kset * TK || tx_valid_in;
            tk_m = t > kset * TK && tx_valid_in;
            b_m = tk_m ? tx_data_in : 8'h7E;
            if (!ld_m) begin
               ptt_m = 0;
               busy = 0;
            end
         end
         tx_valid_in <= q.size() > 0;
         tx_data_in <= (q.size() > 0) ? q[0] : 8'h00;
      end
   end

   initial begin
      rst();
      chk("byte", tx_byte_out, 8'h7E);
      chk("ptt", ptt_out, 1'b0);
      bus(0, CDKD_ADDR_RISE, 32'h11);
      bus(0, CDKD_ADDR_FALL, 32'h11);
      bus(0, CDKD_ADDR_THRESH, 32'h6C);
      bus(0, CDKD_ADDR_KEYUP, 32'h1E);
      bus(1, CDKD_ADDR_STATUS, 32'hFF);
      bus(0, CDKD_ADDR_STATUS, 32'h0);
      bus(0, 8'h20, 32'h0);
      $display("register test done");
      cdp(17, 17, 108);
      cdp(200, 3, 250);
      cdp(40, 60, 100);
      // Penalty heavier than the gain: sense must drop back on a zero count
      cdp(30, 70, 60);
      rst();
      tx_on = 1;
      foreach (ks[i]) begin
         bus(1, CDKD_ADDR_KEYUP, ks[i]);
         kset = ks[i];
         // Short gaps so slots land inside key-up, one right at its last edge
         gap <= 4'(3 - i);
         rnd = nxt(rnd);
         q = '{rnd[7:0], rnd[15:8]};
         go = 1;
         busy = 1;
         // Mid-frame status: keyed, and in key-up unless the delay is zero
         repeat (2) @(posedge ref_clk_in);
         bus(0, CDKD_ADDR_STATUS, (kset != 0) ? 32'h6 : 32'h2);
         for (int k = 0; k < 500 && busy; k++) @(posedge ref_clk_in);
         chk("ended", busy, 1'b0);
         $display("keyup test %0d done", ks[i]);
      end
      end_sim();
   end
endmodule : tb
`default_nettype wire
